// ===== common/trigger_sequencer_defines.vh
// Register offsets, field positions and command encodings of the trigger sequencer register set.
// Assumes an APB slave with 32-bit data; every register takes one aligned word.
`ifndef TRIGGER_SEQUENCER_DEFINES_VH
`define TRIGGER_SEQUENCER_DEFINES_VH

`define OFS_MASK        12'h000
`define OFS_T0LIM       12'h004
`define OFS_T1LIM       12'h008
`define OFS_SDLIM       12'h00c
`define OFS_C0LIM       12'h010
`define OFS_C1LIM       12'h014
`define OFS_COPY        12'h018
`define OFS_ADD         12'h01c
`define OFS_LIT         12'h020
`define OFS_QPTR        12'h024
`define OFS_CTRL        12'h028
`define OFS_CHSEL       12'h02c
`define OFS_QUEUE       12'h040
`define OFS_QUEUE_END   12'h07c

`define CTRL_EN_BIT     0
`define CTRL_RUN_BIT    1
`define CTRL_STEP_BIT   2
`define CTRL_SDEN_BIT   3

`define REG_RESET       16'h0000
`define QPTR_W          5

`define CMD_CTRL        4'h0
`define CMD_ADD         4'h1
`define CMD_COPY        4'h1
`define CMD_STRB0       4'h2
`define CMD_STRB1       4'h3
`define OPT_SD_OFF      4'h2
`define OPT_SD_ON       4'h6
`define OPT_T0          4'h8
`define OPT_T1          4'h9
`define OPT_CH_C0       4'hc
`define OPT_CH_C1       4'hd
`define OPT_CH_LIT      4'he
`define OPT_BCAST       4'hf

`define TGT_C0          3'h0
`define TGT_C1          3'h1
`define TGT_T0          3'h2
`define TGT_T1          3'h3
`define TGT_SD          3'h4
`define TGT_LIT         3'h5

`endif

// ===== src/step_delay_timer.v
// Step delay timer: limit plus one clocks, the start pulse cycle included.
// Assumes start is a one-cycle pulse issued only while idle.
module step_delay_timer (
    input  wire        clk,
    input  wire        rst,
    input  wire        start,
    input  wire [15:0] limit,
    output reg         busy_ff,
    output reg         done_ff
);
    reg [15:0] cnt_ff;

    always @(posedge clk)
    begin
        if (rst)
        begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            cnt_ff  <= 16'h0000;
        end
        else
        begin
            done_ff <= 1'b0;
            if (start)
            begin
                // The start cycle itself counts as the first delay clock
                busy_ff <= (limit != 16'h0000);
                done_ff <= (limit == 16'h0000);
                cnt_ff  <= limit - 16'h0001;
            end
            else if (busy_ff)
            begin
                if (cnt_ff == 16'h0000)
                begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end
                else
                    cnt_ff <= cnt_ff - 16'h0001;
            end
        end
    end
endmodule // step_delay_timer

// ===== src/trigger_sequencer_regs.v
// Trigger sequencer register set with a compact step executor.
// Assumes an APB master on CLK; power-on reset SYS_RST is synchronous and active high.
// Notes on behaviour
// - Broadcast fires each ADC sample trigger whose upper-nibble mask bit is set.
// - Broadcast fires sync pulse to each capture/compare unit with mask bit set.
// - Broadcast fires clock pulse to each compare unit with clock mask bit set.
// - Only control command with broadcast option uses the mask.
// - Writes to all sequencer registers except control ignored while enable and run both set.
// - Timer 0 limit used only by the timer 0 step command.
// - Timer 1 limit used only by the timer 1 step command.
// - With step delay enabled each step is lengthened by limit plus one clocks.
// - Counter 0 limit is loop count of counter 0 jump or counter terminal.
// - Counter 1 limit is loop count of counter 1 jump or counter terminal.
// - Copy command moves hold operand into the selected target.
// - Add command adds adjust operand into the selected target.
// - Literal written to ADC channel select by its control command.
// - Queue pointer is five bits; upper bits read zero.
// - Queue has sixteen words; low byte step 2x, high byte step 2x+1.
// - Queue words are never cleared by any reset.
// - Broadcast fires all enabled outputs in one action.
// - Add/copy option selects target: counter limits, timer limits, step delay limit, literal.
`include "trigger_sequencer_defines.vh"
module trigger_sequencer_regs (
    input  wire        CLK,
    input  wire        SYS_RST,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    input  wire [3:0]  PSTRB,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    output reg  [15:0] TRIGGER_PULSE,
    output reg  [15:0] ADC_CHANNEL_SELECT,
    output reg  [4:0]  ACTIVE_STEP
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_EXEC  = 2'h1;
    localparam ST_WAIT  = 2'h2;
    localparam ST_DELAY = 2'h3;

    reg [15:0] mask_ff, t0lim_ff, t1lim_ff, sdlim_ff, c0lim_ff, c1lim_ff;
    reg [15:0] copy_ff, add_ff, lit_ff;
    reg [15:0] t0_ff, t1_ff, c0_ff, c1_ff;
    reg [4:0]  qptr_ff;
    reg [3:0]  ctrl_ff;
    reg [1:0]  state_ff;
    reg        timer_sel_ff;
    reg [15:0] queue_ff [0:15];
    reg [15:0] nxt_pulse;
    reg [31:0] nxt_rdata;
    reg        nxt_err;
    reg        sd_start;

    wire        access   = PSEL & PENABLE;
    wire        wr       = access & PWRITE;
    wire        running  = ctrl_ff[`CTRL_EN_BIT] & ctrl_ff[`CTRL_RUN_BIT];
    wire        wr_ok    = wr & ~running;
    wire [15:0] wdat     = PWDATA[15:0];
    wire [15:0] cur_word = queue_ff[qptr_ff[4:1]];
    wire [7:0]  step     = qptr_ff[0] ? cur_word[15:8] : cur_word[7:0];
    wire [3:0]  cmd      = step[7:4];
    wire [3:0]  opt      = step[3:0];
    wire        sd_busy;
    wire        sd_done;

    // Merges a 16-bit write under the two low byte strobes
    function [15:0] merge;
        input [15:0] old;
        input [15:0] nw;
        input [1:0]  strb;
        begin
            merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
        end
    endfunction

    function hit;
        input [11:0] a;
        input [11:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    // Aligned word inside the step queue window
    function in_queue;
        input [11:0] a;
        begin
            in_queue = (a >= `OFS_QUEUE) && (a <= `OFS_QUEUE_END) && (a[1:0] == 2'b00);
        end
    endfunction

    // Control command carrying the wanted option
    function ctrl_opt;
        input [3:0] c;
        input [3:0] o;
        input [3:0] want;
        begin
            ctrl_opt = (c == `CMD_CTRL) && (o == want);
        end
    endfunction

    step_delay_timer u_sd (
        .clk     (CLK),
        .rst     (SYS_RST),
        .start   (sd_start),
        .limit   (sdlim_ff),
        .busy_ff (sd_busy),
        .done_ff (sd_done)
    );

    // Queue has no reset term at all
    always @(posedge CLK)
    begin
        if (wr_ok && PREADY && in_queue(PADDR))
            queue_ff[PADDR[5:2]] <= merge(queue_ff[PADDR[5:2]], wdat, PSTRB[1:0]);
    end

    // Read mux and decode error
    always @*
    begin
        nxt_rdata = 32'h0000_0000;
        nxt_err   = 1'b0;
        if (in_queue(PADDR))
            nxt_rdata[15:0] = queue_ff[PADDR[5:2]];
        else
        begin
            case (PADDR)
                `OFS_MASK:  nxt_rdata[15:0] = mask_ff;
                `OFS_T0LIM: nxt_rdata[15:0] = t0lim_ff;
                `OFS_T1LIM: nxt_rdata[15:0] = t1lim_ff;
                `OFS_SDLIM: nxt_rdata[15:0] = sdlim_ff;
                `OFS_C0LIM: nxt_rdata[15:0] = c0lim_ff;
                `OFS_C1LIM: nxt_rdata[15:0] = c1lim_ff;
                `OFS_COPY:  nxt_rdata[15:0] = copy_ff;
                `OFS_ADD:   nxt_rdata[15:0] = add_ff;
                `OFS_LIT:   nxt_rdata[15:0] = lit_ff;
                `OFS_QPTR:  nxt_rdata[4:0]  = qptr_ff;
                `OFS_CTRL:  nxt_rdata[3:0]  = ctrl_ff;
                `OFS_CHSEL: nxt_rdata[15:0] = ADC_CHANNEL_SELECT;
                default:    nxt_err = 1'b1;
            endcase
        end
    end

    // Bus answer: one wait state, answer in the access phase's second cycle
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY  <= access & ~PREADY;
            PRDATA  <= (access & ~PREADY & ~PWRITE) ? nxt_rdata : 32'h0000_0000;
            PSLVERR <= access & ~PREADY & nxt_err;
        end
    end

    wire do_wr = wr_ok & PREADY;

    // Broadcast decode
    always @*
    begin
        nxt_pulse = 16'h0000;
        if (state_ff == ST_EXEC && ctrl_opt(cmd, opt, `OPT_BCAST))
            nxt_pulse = mask_ff;
    end

    // Control register and status
    always @(posedge CLK)
    begin
        if (SYS_RST)
            ctrl_ff <= 4'h0;
        else
        begin
            if (wr & PREADY & hit(PADDR, `OFS_CTRL))
                ctrl_ff <= wdat[3:0];
            // Step delay command wins over a software write in the same cycle
            if (state_ff == ST_EXEC && ctrl_opt(cmd, opt, `OPT_SD_ON))
                ctrl_ff[`CTRL_SDEN_BIT] <= 1'b1;
            else if (state_ff == ST_EXEC && ctrl_opt(cmd, opt, `OPT_SD_OFF))
                ctrl_ff[`CTRL_SDEN_BIT] <= 1'b0;
        end
    end

    // Register file and step executor
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            mask_ff  <= `REG_RESET;
            t0lim_ff <= `REG_RESET;
            t1lim_ff <= `REG_RESET;
            sdlim_ff <= `REG_RESET;
            c0lim_ff <= `REG_RESET;
            c1lim_ff <= `REG_RESET;
            copy_ff  <= `REG_RESET;
            add_ff   <= `REG_RESET;
            lit_ff   <= `REG_RESET;
            qptr_ff  <= 5'h00;
            t0_ff    <= 16'h0000;
            t1_ff    <= 16'h0000;
            c0_ff    <= 16'h0000;
            c1_ff    <= 16'h0000;
            timer_sel_ff <= 1'b0;
            state_ff <= ST_IDLE;
            sd_start <= 1'b0;
            TRIGGER_PULSE      <= 16'h0000;
            ADC_CHANNEL_SELECT <= 16'h0000;
            ACTIVE_STEP        <= 5'h00;
        end
        else
        begin
            sd_start      <= 1'b0;
            TRIGGER_PULSE <= nxt_pulse;
            ACTIVE_STEP   <= qptr_ff;
            if (do_wr)
            begin
                if (hit(PADDR, `OFS_MASK))  mask_ff  <= merge(mask_ff, wdat, PSTRB[1:0]);
                if (hit(PADDR, `OFS_T0LIM)) t0lim_ff <= merge(t0lim_ff, wdat, PSTRB[1:0]);
                if (hit(PADDR, `OFS_T1LIM)) t1lim_ff <= merge(t1lim_ff, wdat, PSTRB[1:0]);
                if (hit(PADDR, `OFS_SDLIM)) sdlim_ff <= merge(sdlim_ff, wdat, PSTRB[1:0]);
                if (hit(PADDR, `OFS_C0LIM)) c0lim_ff <= merge(c0lim_ff, wdat, PSTRB[1:0]);
                if (hit(PADDR, `OFS_C1LIM)) c1lim_ff <= merge(c1lim_ff, wdat, PSTRB[1:0]);
                if (hit(PADDR, `OFS_COPY))  copy_ff  <= merge(copy_ff, wdat, PSTRB[1:0]);
                if (hit(PADDR, `OFS_ADD))   add_ff   <= merge(add_ff, wdat, PSTRB[1:0]);
                if (hit(PADDR, `OFS_LIT))   lit_ff   <= merge(lit_ff, wdat, PSTRB[1:0]);
                if (hit(PADDR, `OFS_QPTR) && PSTRB[0]) qptr_ff <= wdat[4:0];
            end
            case (state_ff)
                ST_IDLE:
                begin
                    if (running)
                        state_ff <= ST_EXEC;
                end
                ST_EXEC:
                begin
                    state_ff <= ST_DELAY;
                    qptr_ff  <= qptr_ff + 5'h01;
                    if (cmd == `CMD_CTRL && (opt == `OPT_T0 || opt == `OPT_T1))
                    begin
                        timer_sel_ff <= opt[0];
                        t0_ff    <= 16'h0000;
                        t1_ff    <= 16'h0000;
                        state_ff <= ST_WAIT;
                    end
                    else if (cmd == `CMD_CTRL && opt == `OPT_CH_C0)
                        ADC_CHANNEL_SELECT <= c0_ff;
                    else if (cmd == `CMD_CTRL && opt == `OPT_CH_C1)
                        ADC_CHANNEL_SELECT <= c1_ff;
                    else if (cmd == `CMD_CTRL && opt == `OPT_CH_LIT)
                        ADC_CHANNEL_SELECT <= lit_ff;
                    else if (cmd == `CMD_STRB0 || cmd == `CMD_STRB1)
                        ADC_CHANNEL_SELECT <= {11'h000, cmd[0], opt};
                    else if (cmd == `CMD_ADD && opt[3] == 1'b0)
                    begin
                        case (opt[2:0])
                            `TGT_C0:  c0lim_ff <= c0lim_ff + add_ff;
                            `TGT_C1:  c1lim_ff <= c1lim_ff + add_ff;
                            `TGT_T0:  t0lim_ff <= t0lim_ff + add_ff;
                            `TGT_T1:  t1lim_ff <= t1lim_ff + add_ff;
                            `TGT_SD:  sdlim_ff <= sdlim_ff + add_ff;
                            `TGT_LIT: lit_ff   <= lit_ff + add_ff;
                            default:  ;
                        endcase
                    end
                    else if (cmd == `CMD_COPY && opt[3] == 1'b1)
                    begin
                        case (opt[2:0])
                            `TGT_C0:  c0lim_ff <= copy_ff;
                            `TGT_C1:  c1lim_ff <= copy_ff;
                            `TGT_T0:  t0lim_ff <= copy_ff;
                            `TGT_T1:  t1lim_ff <= copy_ff;
                            `TGT_SD:  sdlim_ff <= copy_ff;
                            `TGT_LIT: lit_ff   <= copy_ff;
                            default:  ;
                        endcase
                    end
                    else if (cmd[3:1] == 3'h5)
                        qptr_ff <= {cmd[0], opt};
                    else if (cmd[3:1] == 3'h6)
                    begin
                        if (c0_ff == c0lim_ff)
                            c0_ff <= 16'h0000;
                        else
                        begin
                            c0_ff   <= c0_ff + 16'h0001;
                            qptr_ff <= {cmd[0], opt};
                        end
                    end
                    else if (cmd[3:1] == 3'h7)
                    begin
                        if (c1_ff == c1lim_ff)
                            c1_ff <= 16'h0000;
                        else
                        begin
                            c1_ff   <= c1_ff + 16'h0001;
                            qptr_ff <= {cmd[0], opt};
                        end
                    end
                    if (ctrl_ff[`CTRL_SDEN_BIT] && !(cmd == `CMD_CTRL && (opt == `OPT_T0 || opt == `OPT_T1)))
                        sd_start <= 1'b1;
                end
                ST_WAIT:
                begin
                    if (!timer_sel_ff)
                    begin
                        t0_ff <= t0_ff + 16'h0001;
                        if (t0_ff == t0lim_ff)
                        begin
                            state_ff <= ST_DELAY;
                            sd_start <= ctrl_ff[`CTRL_SDEN_BIT];
                        end
                    end
                    else
                    begin
                        t1_ff <= t1_ff + 16'h0001;
                        if (t1_ff == t1lim_ff)
                        begin
                            state_ff <= ST_DELAY;
                            sd_start <= ctrl_ff[`CTRL_SDEN_BIT];
                        end
                    end
                end
                ST_DELAY:
                begin
                    if (!sd_start && !sd_busy)
                        state_ff <= (running && !ctrl_ff[`CTRL_STEP_BIT]) ? ST_EXEC : ST_IDLE;
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
            if (!running)
                state_ff <= ST_IDLE;
        end
    end
endmodule // trigger_sequencer_regs

// ===== tb/trigger_sequencer_regs_asserts.sv
// Checker of the register set's APB answers and trigger outputs.
// Bound to the design's top module; sees its ports only.
`include "trigger_sequencer_defines.vh"
module trigger_sequencer_regs_asserts (
    input wire logic        CLK,
    input wire logic        SYS_RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic [15:0] TRIGGER_PULSE,
    input wire logic [15:0] ADC_CHANNEL_SELECT,
    input wire logic [4:0]  ACTIVE_STEP
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);
    wire rd_done = PREADY && PSEL && PENABLE && !PWRITE;
    wire in_hole = PADDR > 12'h02c && PADDR < 12'h040;
    sequence setup_s;
        PSEL && !PENABLE;
    endsequence
    sequence answer_s;
        !PREADY ##1 PREADY;
    endsequence
    one_wait_a: assert property (setup_s |=> answer_s)
        else $error("ready not after one wait state");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    idle_data_a: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside answer");
    hole_error_a: assert property (PREADY && in_hole |-> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (PREADY && !in_hole && PADDR <= 12'h07c && PADDR[1:0] == 2'h0 |-> !PSLVERR)
        else $error("mapped access refused");
    qptr_width_a: assert property (rd_done && PADDR == `OFS_QPTR |-> PRDATA[31:5] == 27'h0)
        else $error("pointer upper bits set");
    trig_pulse_a: assert property (TRIGGER_PULSE != 16'h0 |=> TRIGGER_PULSE == 16'h0)
        else $error("trigger longer than one cycle");
    chsel_read_a: assert property (rd_done && PADDR == `OFS_CHSEL |-> PRDATA[15:0] == ADC_CHANNEL_SELECT)
        else $error("channel select readback differs");
    reset_clear_a: assert property ($fell(SYS_RST) |-> TRIGGER_PULSE == 16'h0 && ADC_CHANNEL_SELECT == 16'h0
        && ACTIVE_STEP == 5'h0 && !PREADY)
        else $error("outputs not clear after reset");
endmodule // trigger_sequencer_regs_asserts

bind trigger_sequencer_regs trigger_sequencer_regs_asserts u_chk (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE),
    .PADDR(PADDR),
    .PRDATA(PRDATA),
    .PREADY(PREADY),
    .PSLVERR(PSLVERR),
    .TRIGGER_PULSE(TRIGGER_PULSE),
    .ADC_CHANNEL_SELECT(ADC_CHANNEL_SELECT),
    .ACTIVE_STEP(ACTIVE_STEP)
);

// ===== tb/trigger_sink.sv
// Far-side model: trigger inputs of compare, capture and ADC units.
// Samples the pulse bus on the system clock.
module trigger_sink (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [15:0] pulse,
    output logic     [15:0] seen,
    output int              count
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(posedge clk)
    begin
        if (rst)
        begin
            seen  <= 16'h0;
            count <= 0;
        end
        else if (pulse != 16'h0)
        begin
            seen  <= seen | pulse;
            count <= count + 1;
        end
    end
endmodule // trigger_sink

// ===== tb/tb_trigger_sequencer_register_set.sv
// Testbench of the trigger sequencer register set.
// Drives APB on CLK; runs two short step programs and checks registers and triggers.
`include "trigger_sequencer_defines.vh"
module tb_trigger_sequencer_register_set;
    timeunit 1ns;
    timeprecision 1ns;
    logic        CLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0;
    logic [3:0]  PSTRB = 4'h0;
    wire  [31:0] PRDATA;
    wire         PREADY;
    wire         PSLVERR;
    wire  [15:0] TRIGGER_PULSE;
    wire  [15:0] ADC_CHANNEL_SELECT;
    wire  [4:0]  ACTIVE_STEP;
    logic [15:0] seen;
    int          count;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cycles = 0;
    int          i;
    int          stamp [0:7];
    int          n_pulse = 0;
    int          p0;
    logic [31:0] rd;
    logic        err;
    logic [11:0] a;

    trigger_sequencer_regs u_dut (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .PSEL(PSEL),
        .PENABLE(PENABLE),
        .PWRITE(PWRITE),
        .PADDR(PADDR),
        .PWDATA(PWDATA),
        .PSTRB(PSTRB),
        .PRDATA(PRDATA),
        .PREADY(PREADY),
        .PSLVERR(PSLVERR),
        .TRIGGER_PULSE(TRIGGER_PULSE),
        .ADC_CHANNEL_SELECT(ADC_CHANNEL_SELECT),
        .ACTIVE_STEP(ACTIVE_STEP)
    );
    trigger_sink u_sink (.clk(CLK), .rst(SYS_RST), .pulse(TRIGGER_PULSE), .seen(seen), .count(count));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits for the answer and checks it comes after one wait state
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data, input logic [3:0] strb);
        int k;
        @(posedge CLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= wr;
        PADDR   <= addr;
        PWDATA  <= data;
        PSTRB   <= strb;
        @(posedge CLK);
        PENABLE <= 1'b1;
        @(posedge CLK);
        k = 1;
        while (PREADY !== 1'b1)
        begin
            @(posedge CLK);
            k++;
        end
        chk(32'(k), 32'h2);
        rd      = PRDATA;
        err     = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] addr, input logic [15:0] data);
        apb(1'b1, addr, {16'h0, data}, 4'h3);
    endtask

    task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0, 4'h0);
        chk(rd, exp);
    endtask

    task automatic do_reset;
        SYS_RST <= 1'b1;
        repeat (6) @(posedge CLK);
        SYS_RST <= 1'b0;
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always #5 CLK = ~CLK;

    always @(posedge CLK)
    begin
        cycles++;
        if (TRIGGER_PULSE != 16'h0000 && !SYS_RST && n_pulse < 8)
        begin
            stamp[n_pulse] = cycles;
            n_pulse++;
        end
        if (cycles == 5000)
        begin
            n_errors++;
            finish_test;
        end
    end

    initial
    begin
        do_reset;
        for (a = 12'h000; a <= `OFS_CHSEL; a += 12'h004)
            rdchk(a, 32'h0);
        for (a = 12'h000; a <= `OFS_LIT; a += 12'h004)
        begin
            wr(a, 16'hffff);
            rdchk(a, 32'h0000ffff);
        end
        apb(1'b1, `OFS_T0LIM, 32'h0000abcd, 4'h1);
        rdchk(`OFS_T0LIM, 32'h0000ffcd);
        wr(`OFS_QPTR, 16'hffff);
        rdchk(`OFS_QPTR, 32'h0000001f);
        apb(1'b0, 12'h030, 32'h0, 4'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        // Copy to literal, add, literal to channel select, broadcast, then loop
        wr(`OFS_QPTR, 16'h0000);
        wr(`OFS_COPY, 16'h1234);
        wr(`OFS_ADD, 16'h0101);
        wr(`OFS_MASK, 16'ha5c3);
        wr(`OFS_QUEUE, {`CMD_ADD, 4'h5, `CMD_COPY, 4'hd});
        wr(`OFS_QUEUE + 12'h004, {`CMD_CTRL, `OPT_BCAST, `CMD_CTRL, `OPT_CH_LIT});
        wr(`OFS_QUEUE + 12'h008, 16'h00a4);
        wr(`OFS_CTRL, 16'h0003);
        for (i = 0; i < 200; i++)
        begin
            @(posedge CLK);
            if (seen !== 16'h0)
                break;
        end
        wr(`OFS_MASK, 16'hffff);
        rdchk(`OFS_MASK, 32'h0000a5c3);
        wr(`OFS_LIT, 16'h0000);
        rdchk(`OFS_LIT, 32'h00001335);
        wr(`OFS_CTRL, 16'h0000);
        chk({16'h0, seen}, 32'h0000a5c3);
        chk(32'(count), 32'h1);
        chk({16'h0, ADC_CHANNEL_SELECT}, 32'h00001335);
        rdchk(`OFS_CHSEL, 32'h00001335);
        chk({27'h0, ACTIVE_STEP}, 32'h00000004);
        do_reset;
        rdchk(`OFS_QUEUE, 32'h0000151d);
        rdchk(`OFS_QUEUE + 12'h004, 32'h00000f0e);
        rdchk(`OFS_MASK, 32'h0);
        // Second program: step delay timing, then a loop on counter 0
        wr(`OFS_SDLIM, 16'h0005);
        wr(`OFS_C0LIM, 16'h0002);
        wr(`OFS_ADD, 16'h0001);
        wr(`OFS_MASK, 16'h0001);
        wr(`OFS_QUEUE, {`CMD_CTRL, `OPT_BCAST, `CMD_CTRL, `OPT_BCAST});
        wr(`OFS_QUEUE + 12'h004, {`CMD_CTRL, `OPT_BCAST, `CMD_CTRL, `OPT_SD_ON});
        wr(`OFS_QUEUE + 12'h008, {`CMD_CTRL, `OPT_SD_OFF, `CMD_CTRL, `OPT_BCAST});
        wr(`OFS_QUEUE + 12'h00c, 16'hc615);
        wr(`OFS_QUEUE + 12'h010, 16'ha90e);
        p0 = n_pulse;
        wr(`OFS_CTRL, 16'h0003);
        repeat (100) @(posedge CLK);
        wr(`OFS_CTRL, 16'h0000);
        chk(32'(n_pulse - p0), 32'h4);
        chk(32'((stamp[p0 + 3] - stamp[p0 + 2]) - (stamp[p0 + 1] - stamp[p0])), 32'h6);
        chk({16'h0, ADC_CHANNEL_SELECT}, 32'h00000003);
        rdchk(`OFS_QPTR, 32'h00000009);
        finish_test;
    end
endmodule // tb_trigger_sequencer_register_set
